// file: inc/pcbt_regs.vh
// Purpose: Register map, field positions and reset values of the compare batch transfer block.
// Assumes: AXI4-Lite with 32-bit data, byte addresses, one aligned word per register.
// Notes: Compare registers are 16 bits wide and sit in the low half of their word.
`ifndef PCBT_REGS_VH
`define PCBT_REGS_VH

// ==========================================================================
// Register byte offsets
`define PCBT_OFF_PERIOD 8'h00
`define PCBT_OFF_DUTY1 8'h04
`define PCBT_OFF_DUTY2 8'h08
`define PCBT_OFF_DUTY3 8'h0C
`define PCBT_OFF_CULL 8'h10
`define PCBT_OFF_SLAVE0 8'h14
`define PCBT_OFF_SLAVE1 8'h18
`define PCBT_OFF_CTRL 8'h1C
`define PCBT_OFF_STATUS 8'h20
`define PCBT_OFF_PERIOD_BUF 8'h24

// ==========================================================================
// Field positions
`define PCBT_CULL_CNT_MSB 4
`define PCBT_CULL_VALLEY_EN 5
`define PCBT_CULL_CREST_EN 6
`define PCBT_CTRL_ANYTIME 0
`define PCBT_CTRL_CULL_EN 1
`define PCBT_CTRL_RUN 2
`define PCBT_STAT_PENDING 0
`define PCBT_STAT_DOWN 1

// ==========================================================================
// Reset values and constants
`define PCBT_RST_COMPARE 16'h0000
`define PCBT_RST_CULL 8'h00
`define PCBT_RST_CTRL 3'h0
`define PCBT_VALLEY_COUNT 16'h0001
`define PCBT_RESP_OKAY 2'h0
`define PCBT_RESP_SLVERR 2'h2

`endif

// file: src/pcbt_cull.v
// Purpose: Interrupt culling counter for crest and valley events.
// Assumes: Events are single-cycle pulses on the timer clock.
// Notes: Fire outputs are combinational so a transfer can happen in the event cycle.
`timescale 1ns/100ps

module pcbt_cull
#(
  parameter CNT_W = 5
)
(
  input wire aclk,
  input wire aresetn,
  input wire clear,
  input wire crest_ev,
  input wire valley_ev,
  input wire crest_irq_enable,
  input wire valley_irq_enable,
  input wire [CNT_W-1:0] cull_count_field,
  output wire crest_fire,
  output wire valley_fire
);

  reg [CNT_W-1:0] seen_reg;
  wire counted;
  wire hit;

  // ==========================================================================
  // Only enabled event kinds are counted; the (count+1)-th one fires, so zero fires every time.
  assign counted = (crest_ev & crest_irq_enable) | (valley_ev & valley_irq_enable);
  assign hit = counted & (seen_reg == cull_count_field);
  assign crest_fire = hit & crest_ev;
  assign valley_fire = hit & valley_ev;

  always @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      seen_reg <= {CNT_W{1'b0}};
    end
    else if (hit)
    begin
      seen_reg <= {CNT_W{1'b0}};
    end
    else if (counted)
    begin
      seen_reg <= seen_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// file: src/pcbt_top.v
// Purpose: Double-buffer transfer of compare values into a master up/down timer and a slave timer.
// Assumes: Single clock aclk, synchronous active-low reset, AXI4-Lite register access.
// Notes: PWM output shaping, dead time and A/D trigger tuning live elsewhere.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "pcbt_regs.vh"

module pcbt_top
#(
  parameter ADDR_W = 8,
  parameter CMP_W = 16,
  parameter CULL_W = 5
)
(
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [CMP_W-1:0] period_buf_reg,
  output reg [CMP_W-1:0] duty1_buf_reg,
  output reg [CMP_W-1:0] duty2_buf_reg,
  output reg [CMP_W-1:0] duty3_buf_reg,
  output reg [7:0] cull_buf_reg,
  output reg [CMP_W-1:0] slave0_buf_reg,
  output reg [CMP_W-1:0] slave1_buf_reg,
  output reg [CMP_W-1:0] master_count_reg,
  output reg count_down_reg,
  output reg [CMP_W-1:0] slave_count_reg,
  output reg crest_interrupt,
  output reg valley_interrupt,
  output reg transfer_pulse
);

  // ==========================================================================
  // Software-side registers
  reg [CMP_W-1:0] period_compare_reg;
  reg [CMP_W-1:0] phase1_duty_compare;
  reg [CMP_W-1:0] phase2_duty_compare;
  reg [CMP_W-1:0] phase3_duty_compare;
  reg [7:0] culling_option_reg;
  reg [CMP_W-1:0] slave_compare0;
  reg [CMP_W-1:0] slave_compare1;
  reg [2:0] ctrl_reg;
  reg pending_reg;
  reg pending_next;

  // ==========================================================================
  // AXI4-Lite slave state
  reg aw_full_reg;
  reg w_full_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire do_write;
  wire aw_full_next;
  wire w_full_next;
  wire bvalid_next;
  wire rvalid_next;
  reg wr_known;
  reg [31:0] rd_word;
  reg rd_known;

  function [31:0] pcbt_merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] strb;
    integer i;
    begin
      pcbt_merge = old_word;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (strb[i])
        begin
          pcbt_merge[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  assign aw_take = s_axi_awready & s_axi_awvalid;
  assign w_take = s_axi_wready & s_axi_wvalid;
  assign ar_take = s_axi_arready & s_axi_arvalid;
  assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign aw_full_next = do_write ? 1'b0 : (aw_take ? 1'b1 : aw_full_reg);
  assign w_full_next = do_write ? 1'b0 : (w_take ? 1'b1 : w_full_reg);
  assign bvalid_next = do_write ? 1'b1 : ((s_axi_bvalid & s_axi_bready) ? 1'b0 : s_axi_bvalid);
  assign rvalid_next = ar_take ? 1'b1 : ((s_axi_rvalid & s_axi_rready) ? 1'b0 : s_axi_rvalid);

  // ==========================================================================
  // Address decode for writes and reads
  wire sel_period = do_write && (aw_addr_reg == `PCBT_OFF_PERIOD);
  wire sel_duty1 = do_write && (aw_addr_reg == `PCBT_OFF_DUTY1);
  wire sel_duty2 = do_write && (aw_addr_reg == `PCBT_OFF_DUTY2);
  wire sel_duty3 = do_write && (aw_addr_reg == `PCBT_OFF_DUTY3);
  wire sel_cull = do_write && (aw_addr_reg == `PCBT_OFF_CULL);
  wire sel_slave0 = do_write && (aw_addr_reg == `PCBT_OFF_SLAVE0);
  wire sel_slave1 = do_write && (aw_addr_reg == `PCBT_OFF_SLAVE1);
  wire sel_ctrl = do_write && (aw_addr_reg == `PCBT_OFF_CTRL);

  wire [31:0] wr_period = pcbt_merge({16'h0000, period_compare_reg}, w_data_reg, w_strb_reg);
  wire [31:0] wr_duty1 = pcbt_merge({16'h0000, phase1_duty_compare}, w_data_reg, w_strb_reg);
  wire [31:0] wr_duty2 = pcbt_merge({16'h0000, phase2_duty_compare}, w_data_reg, w_strb_reg);
  wire [31:0] wr_duty3 = pcbt_merge({16'h0000, phase3_duty_compare}, w_data_reg, w_strb_reg);
  wire [31:0] wr_cull = pcbt_merge({24'h000000, culling_option_reg}, w_data_reg, w_strb_reg);
  wire [31:0] wr_slave0 = pcbt_merge({16'h0000, slave_compare0}, w_data_reg, w_strb_reg);
  wire [31:0] wr_slave1 = pcbt_merge({16'h0000, slave_compare1}, w_data_reg, w_strb_reg);
  wire [31:0] wr_ctrl = pcbt_merge({29'h00000000, ctrl_reg}, w_data_reg, w_strb_reg);

  always @*
  begin
    wr_known = 1'b1;
    if (aw_addr_reg == `PCBT_OFF_STATUS || aw_addr_reg == `PCBT_OFF_PERIOD_BUF)
    begin
      wr_known = 1'b1;
    end
    else if (aw_addr_reg > `PCBT_OFF_CTRL || aw_addr_reg[1:0] != 2'h0)
    begin
      wr_known = 1'b0;
    end
  end

  always @*
  begin
    rd_word = 32'h00000000;
    rd_known = 1'b1;
    if (s_axi_araddr == `PCBT_OFF_PERIOD)
      rd_word = {16'h0000, period_compare_reg};
    else if (s_axi_araddr == `PCBT_OFF_DUTY1)
      rd_word = {16'h0000, phase1_duty_compare};
    else if (s_axi_araddr == `PCBT_OFF_DUTY2)
      rd_word = {16'h0000, phase2_duty_compare};
    else if (s_axi_araddr == `PCBT_OFF_DUTY3)
      rd_word = {16'h0000, phase3_duty_compare};
    else if (s_axi_araddr == `PCBT_OFF_CULL)
      rd_word = {24'h000000, culling_option_reg};
    else if (s_axi_araddr == `PCBT_OFF_SLAVE0)
      rd_word = {16'h0000, slave_compare0};
    else if (s_axi_araddr == `PCBT_OFF_SLAVE1)
      rd_word = {16'h0000, slave_compare1};
    else if (s_axi_araddr == `PCBT_OFF_CTRL)
      rd_word = {29'h00000000, ctrl_reg};
    else if (s_axi_araddr == `PCBT_OFF_STATUS)
      rd_word = {master_count_reg, 14'h0000, count_down_reg, pending_reg};
    else if (s_axi_araddr == `PCBT_OFF_PERIOD_BUF)
      rd_word = {16'h0000, period_buf_reg};
    else
      rd_known = 1'b0;
  end

  // ==========================================================================
  // Bus handshakes; ready drops while a word is held or an answer waits.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCBT_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PCBT_RESP_OKAY;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      s_axi_awready <= ~aw_full_next & ~bvalid_next;
      s_axi_wready <= ~w_full_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (aw_take)
        aw_addr_reg <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
        s_axi_bresp <= wr_known ? `PCBT_RESP_OKAY : `PCBT_RESP_SLVERR;
      if (ar_take)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? `PCBT_RESP_OKAY : `PCBT_RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // Mode selection and transfer points
  wire anytime_rewrite_select = ctrl_reg[`PCBT_CTRL_ANYTIME];
  wire transfer_cull_enable = ctrl_reg[`PCBT_CTRL_CULL_EN];
  wire timer_run = ctrl_reg[`PCBT_CTRL_RUN];
  wire intermittent_mode = ~anytime_rewrite_select & transfer_cull_enable;
  wire crest_ev = timer_run & ~count_down_reg & (master_count_reg == period_buf_reg);
  wire valley_ev = timer_run & count_down_reg & (master_count_reg == `PCBT_VALLEY_COUNT);
  wire crest_fire;
  wire valley_fire;
  wire cull_clear = sel_cull & anytime_rewrite_select;
  // Plain batch takes every crest and valley; intermittent only the culled interrupts.
  wire point = intermittent_mode ? (crest_fire | valley_fire) : (crest_ev | valley_ev);
  wire xfer = pending_reg & point & ~anytime_rewrite_select;
  wire xfer_at_crest = xfer & crest_ev;
  wire [CMP_W-1:0] next_period = xfer_at_crest ? period_compare_reg : period_buf_reg;

  pcbt_cull #(.CNT_W(CULL_W)) pcbt_cull_inst
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(cull_clear),
    .crest_ev(crest_ev),
    .valley_ev(valley_ev),
    .crest_irq_enable(cull_buf_reg[`PCBT_CULL_CREST_EN]),
    .valley_irq_enable(cull_buf_reg[`PCBT_CULL_VALLEY_EN]),
    .cull_count_field(cull_buf_reg[`PCBT_CULL_CNT_MSB:0]),
    .crest_fire(crest_fire),
    .valley_fire(valley_fire)
  );

  // A new arming write wins over a transfer or select clear in the same cycle.
  always @*
  begin
    pending_next = pending_reg;
    if (sel_duty1 && !anytime_rewrite_select)
      pending_next = 1'b1;
    else if (xfer || (sel_ctrl && wr_ctrl[`PCBT_CTRL_ANYTIME]))
      pending_next = 1'b0;
  end

  // ==========================================================================
  // Software registers, request flag and buffers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_compare_reg <= `PCBT_RST_COMPARE;
      phase1_duty_compare <= `PCBT_RST_COMPARE;
      phase2_duty_compare <= `PCBT_RST_COMPARE;
      phase3_duty_compare <= `PCBT_RST_COMPARE;
      culling_option_reg <= `PCBT_RST_CULL;
      slave_compare0 <= `PCBT_RST_COMPARE;
      slave_compare1 <= `PCBT_RST_COMPARE;
      ctrl_reg <= `PCBT_RST_CTRL;
      pending_reg <= 1'b0;
      period_buf_reg <= `PCBT_RST_COMPARE;
      duty1_buf_reg <= `PCBT_RST_COMPARE;
      duty2_buf_reg <= `PCBT_RST_COMPARE;
      duty3_buf_reg <= `PCBT_RST_COMPARE;
      cull_buf_reg <= `PCBT_RST_CULL;
      slave0_buf_reg <= `PCBT_RST_COMPARE;
      slave1_buf_reg <= `PCBT_RST_COMPARE;
      transfer_pulse <= 1'b0;
    end
    else
    begin
      if (sel_period) period_compare_reg <= wr_period[CMP_W-1:0];
      if (sel_duty1) phase1_duty_compare <= wr_duty1[CMP_W-1:0];
      if (sel_duty2) phase2_duty_compare <= wr_duty2[CMP_W-1:0];
      if (sel_duty3) phase3_duty_compare <= wr_duty3[CMP_W-1:0];
      if (sel_cull) culling_option_reg <= wr_cull[7:0];
      if (sel_slave0) slave_compare0 <= wr_slave0[CMP_W-1:0];
      if (sel_slave1) slave_compare1 <= wr_slave1[CMP_W-1:0];
      if (sel_ctrl) ctrl_reg <= wr_ctrl[2:0];
      pending_reg <= pending_next;
      transfer_pulse <= xfer;
      if (xfer)
      begin
        // All seven values move together; the buffers see the pre-write values.
        period_buf_reg <= period_compare_reg;
        duty1_buf_reg <= phase1_duty_compare;
        duty2_buf_reg <= phase2_duty_compare;
        duty3_buf_reg <= phase3_duty_compare;
        cull_buf_reg <= culling_option_reg;
        slave0_buf_reg <= slave_compare0;
        slave1_buf_reg <= slave_compare1;
      end
      else if (anytime_rewrite_select)
      begin
        if (sel_period) period_buf_reg <= wr_period[CMP_W-1:0];
        if (sel_duty1) duty1_buf_reg <= wr_duty1[CMP_W-1:0];
        if (sel_duty2) duty2_buf_reg <= wr_duty2[CMP_W-1:0];
        if (sel_duty3) duty3_buf_reg <= wr_duty3[CMP_W-1:0];
        if (sel_cull) cull_buf_reg <= wr_cull[7:0];
        if (sel_slave0) slave0_buf_reg <= wr_slave0[CMP_W-1:0];
        if (sel_slave1) slave1_buf_reg <= wr_slave1[CMP_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Master up/down counter, slave up counter and interrupts
  always @(posedge aclk)
  begin
    if (!aresetn || !timer_run)
    begin
      master_count_reg <= {CMP_W{1'b0}};
      count_down_reg <= 1'b0;
      slave_count_reg <= {CMP_W{1'b0}};
      crest_interrupt <= 1'b0;
      valley_interrupt <= 1'b0;
    end
    else
    begin
      crest_interrupt <= crest_fire;
      valley_interrupt <= valley_fire;
      if (crest_ev)
      begin
        // The reload keeps the down slope right even when the period just changed.
        master_count_reg <= next_period + {{(CMP_W-1){1'b0}}, 1'b1};
        count_down_reg <= 1'b1;
      end
      else if (valley_ev)
      begin
        master_count_reg <= {CMP_W{1'b0}};
        count_down_reg <= 1'b0;
      end
      else if (count_down_reg)
        master_count_reg <= master_count_reg - {{(CMP_W-1){1'b0}}, 1'b1};
      else
        master_count_reg <= master_count_reg + {{(CMP_W-1){1'b0}}, 1'b1};
      if (slave_count_reg >= period_buf_reg)
        slave_count_reg <= {CMP_W{1'b0}};
      else
        slave_count_reg <= slave_count_reg + {{(CMP_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// file: tb/pcbt_top_props.sv
// Purpose: Port-level checks of transfer points, counter turns and buffer updates.
// Assumes: Bound into pcbt_top; single clock aclk, synchronous active-low aresetn.
// Notes: A crest needs a nonzero period buffer, so a stopped counter never counts as a match.
`timescale 1ns/100ps
`include "pcbt_regs.vh"

module pcbt_top_props
#(
  parameter CMP_W = 16
)
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire [CMP_W-1:0] period_buf_reg,
  input wire [CMP_W-1:0] duty1_buf_reg,
  input wire [CMP_W-1:0] master_count_reg,
  input wire count_down_reg,
  input wire crest_interrupt,
  input wire valley_interrupt,
  input wire transfer_pulse
);
  // ==========================================================================
  // Match points
  wire crest_pt;
  wire valley_pt;
  assign crest_pt = !count_down_reg && (master_count_reg == period_buf_reg) && (period_buf_reg != {CMP_W{1'b0}});
  assign valley_pt = count_down_reg && (master_count_reg == `PCBT_VALLEY_COUNT);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Properties
  property p_xfer_point;
    transfer_pulse |-> $past(crest_pt) || $past(valley_pt);
  endproperty
  a_xfer_point: assert property (p_xfer_point) else $error("transfer away from a crest or valley");

  property p_crest_reload;
    crest_pt |=> count_down_reg && (master_count_reg == period_buf_reg + 16'h0001);
  endproperty
  a_crest_reload: assert property (p_crest_reload) else $error("crest did not reload period plus one");

  property p_valley_turn;
    valley_pt |=> !count_down_reg && (master_count_reg == 16'h0000);
  endproperty
  a_valley_turn: assert property (p_valley_turn) else $error("valley did not turn the counter up");

  property p_crest_irq;
    crest_interrupt |-> $past(crest_pt);
  endproperty
  a_crest_irq: assert property (p_crest_irq) else $error("crest interrupt without a crest");

  property p_valley_irq;
    valley_interrupt |-> $past(valley_pt);
  endproperty
  a_valley_irq: assert property (p_valley_irq) else $error("valley interrupt without a valley");

  property p_single;
    transfer_pulse |=> !transfer_pulse;
  endproperty
  a_single: assert property (p_single) else $error("transfer repeated on the next cycle");

  property p_buf_cause;
    ($changed(duty1_buf_reg) || $changed(period_buf_reg)) |-> transfer_pulse || $rose(s_axi_bvalid);
  endproperty
  a_buf_cause: assert property (p_buf_cause) else $error("buffer changed without a transfer or write");

  property p_reset_clear;
    $rose(aresetn) |-> !transfer_pulse && (period_buf_reg == 16'h0000) && (duty1_buf_reg == 16'h0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");
endmodule

bind pcbt_top pcbt_top_props #(.CMP_W(CMP_W)) pcbt_top_props_inst (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid),
  .period_buf_reg(period_buf_reg),
  .duty1_buf_reg(duty1_buf_reg),
  .master_count_reg(master_count_reg),
  .count_down_reg(count_down_reg),
  .crest_interrupt(crest_interrupt),
  .valley_interrupt(valley_interrupt),
  .transfer_pulse(transfer_pulse)
);

// file: tb/tb_top.sv
// Purpose: Register-level tests of batch, intermittent and anytime compare transfers.
// Assumes: AXI4-Lite map of pcbt_regs.vh; periods long enough for several writes per half cycle.
// Notes: Tests sync to counter turns so each arming write lands in a known half of the triangle.
`timescale 1ns/100ps
`include "pcbt_regs.vh"
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] period_buf_reg, duty1_buf_reg, duty2_buf_reg, duty3_buf_reg, slave0_buf_reg, slave1_buf_reg;
  wire [15:0] master_count_reg;
  wire [7:0] cull_buf_reg;
  wire count_down_reg, crest_interrupt, valley_interrupt, transfer_pulse;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int xfer_cnt = 0;
  int n0;
  logic [31:0] rd;
  logic [1:0] rsp;

  pcbt_top pcbt_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .period_buf_reg(period_buf_reg), .duty1_buf_reg(duty1_buf_reg), .duty2_buf_reg(duty2_buf_reg),
    .duty3_buf_reg(duty3_buf_reg), .cull_buf_reg(cull_buf_reg), .slave0_buf_reg(slave0_buf_reg),
    .slave1_buf_reg(slave1_buf_reg), .master_count_reg(master_count_reg), .count_down_reg(count_down_reg),
    .slave_count_reg(), .crest_interrupt(crest_interrupt), .valley_interrupt(valley_interrupt),
    .transfer_pulse(transfer_pulse)
  );

  // ==========================================================================
  // Clock, transfer counter and hang guard
  always #5 aclk = ~aclk;

  always @(posedge aclk)
  begin
    cyc++;
    if (transfer_pulse === 1'b1)
      xfer_cnt++;
    if (cyc == 5000)
    begin
      fail_count++;
      give_verdict;
    end
  end

  task give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Bus tasks
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Waits are bounded; a stuck counter shows up as a mismatch, not a hang.
  task automatic wait_down(input logic v);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      #1;
      n++;
    end while (count_down_reg !== v && n < 400);
    `CHK(count_down_reg, v)
  endtask

  task automatic wait_turn(input logic v);
    wait_down(~v);
    wait_down(v);
  endtask

  task automatic wait_xfer;
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      #1;
      n++;
    end while (transfer_pulse !== 1'b1 && n < 400);
    `CHK(transfer_pulse, 1'b1)
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    `CHK(period_buf_reg, 16'h0000)
    axi_wr(8'h28, 32'h00000001);
    `CHK(rsp, `PCBT_RESP_SLVERR)
    axi_rd(`PCBT_OFF_STATUS);
    `CHK(rd[0], 1'b0)
    axi_wr(`PCBT_OFF_CTRL, 32'h00000001);
    axi_wr(`PCBT_OFF_PERIOD, 32'h00000040);
    `CHK(period_buf_reg, 16'h0040)
    axi_wr(`PCBT_OFF_CULL, 32'h00000000);
    axi_wr(`PCBT_OFF_CTRL, 32'h00000004);
    axi_wr(`PCBT_OFF_DUTY2, 32'h00000005);
    wait_turn(1'b1);
    wait_turn(1'b1);
    `CHK(duty2_buf_reg, 16'h0000)
    axi_wr(`PCBT_OFF_SLAVE0, 32'h00000003);
    axi_wr(`PCBT_OFF_DUTY1, 32'h00000006);
    axi_rd(`PCBT_OFF_STATUS);
    `CHK(rd[0], 1'b1)
    wait_xfer;
    `CHK({count_down_reg, master_count_reg}, 17'h00000)
    `CHK({duty1_buf_reg, duty2_buf_reg, slave0_buf_reg}, 48'h000600050003)
    axi_rd(`PCBT_OFF_STATUS);
    `CHK(rd[0], 1'b0)
    n0 = xfer_cnt;
    wait_turn(1'b1);
    wait_turn(1'b0);
    `CHK(xfer_cnt, n0)
    axi_wr(`PCBT_OFF_PERIOD, 32'h00000030);
    axi_wr(`PCBT_OFF_DUTY1, 32'h00000006);
    wait_xfer;
    `CHK({count_down_reg, master_count_reg}, 17'h10031)
    `CHK(period_buf_reg, 16'h0030)
    axi_wr(`PCBT_OFF_PERIOD, 32'h00000038);
    axi_wr(`PCBT_OFF_DUTY1, 32'h00000007);
    wait_xfer;
    `CHK({period_buf_reg, master_count_reg}, 32'h00380000)
    wait_down(1'b1);
    `CHK(master_count_reg, 16'h0039)
    axi_wr(`PCBT_OFF_DUTY1, 32'h00000007);
    axi_wr(`PCBT_OFF_CTRL, 32'h00000005);
    axi_rd(`PCBT_OFF_STATUS);
    `CHK(rd[0], 1'b0)
    axi_wr(`PCBT_OFF_CTRL, 32'h00000004);
    n0 = xfer_cnt;
    wait_turn(1'b0);
    wait_turn(1'b1);
    `CHK(xfer_cnt, n0)
    // Only enables are set outside intermittent mode; culling counts change there alone.
    axi_wr(`PCBT_OFF_CTRL, 32'h00000005);
    axi_wr(`PCBT_OFF_CULL, 32'h00000040);
    `CHK(cull_buf_reg, 8'h40)
    axi_wr(`PCBT_OFF_CTRL, 32'h00000006);
    axi_wr(`PCBT_OFF_CULL, 32'h00000041);
    axi_wr(`PCBT_OFF_PERIOD, 32'h00000034);
    axi_wr(`PCBT_OFF_DUTY1, 32'h00000009);
    wait_xfer;
    `CHK({crest_interrupt, count_down_reg, duty1_buf_reg}, 18'h30009)
    `CHK({cull_buf_reg, master_count_reg}, 24'h410035)
    axi_wr(`PCBT_OFF_CULL, 32'h00000021);
    axi_wr(`PCBT_OFF_PERIOD, 32'h00000030);
    axi_wr(`PCBT_OFF_DUTY1, 32'h00000009);
    n0 = xfer_cnt;
    wait_turn(1'b1);
    `CHK(xfer_cnt, n0)
    `CHK({crest_interrupt, transfer_pulse}, 2'b00)
    wait_xfer;
    `CHK({crest_interrupt, cull_buf_reg, master_count_reg}, 25'h1210031)
    axi_wr(`PCBT_OFF_PERIOD, 32'h0000002C);
    axi_wr(`PCBT_OFF_DUTY1, 32'h00000009);
    wait_xfer;
    `CHK({valley_interrupt, master_count_reg}, 17'h10000)
    `CHK(period_buf_reg, 16'h002C)
    wait_down(1'b1);
    `CHK(master_count_reg, 16'h002D)
    give_verdict;
  end
endmodule
